// file: hdl/tsm_cfg.svh
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH
// message word addresses
`define TSM_ADDR_STATUS     5'h01
`define TSM_ADDR_COARSE_LSW 5'h03
`define TSM_ADDR_PULSE_LSW  5'h05
`define TSM_ADDR_WAVE_MSW   5'h06
`define TSM_ADDR_WAVE_LSW   5'h09
// status field bit positions
`define TSM_BIT_ZERO        15
`define TSM_BIT_PULSE       14
`define TSM_BIT_WAVE        13
`define TSM_BIT_INIT        12
// timing, in phase references; the aux divider in bus clock rises
`define TSM_SYNC_TIMEOUT    4456448
`define TSM_WINDOW_REFS     2097152
`define TSM_AUX_REF_DIV     1024
// host clock generation
`define TSM_CLK_NS          8
`define TSM_BUSCLK_NS       125
`define TSM_OSC_NS          60
// host register offsets
`define TSM_REG_CTRL        8'h00
`define TSM_REG_EVENT       8'h04
`define TSM_REG_MASK        8'h08
`define TSM_REG_BUSY        8'h0C
`define TSM_REG_WORD1       8'h10
`define TSM_REG_WORD9       8'h30
// host ctrl and event bits
`define TSM_CTRL_SEND_MSG   0
`define TSM_CTRL_SEND_MARK  1
`endif

// file: hdl/tsm_device.sv
// Added by the designer: the message port, the elapsed time counter and the field hand-off.
`include "tsm_cfg.svh"
`default_nettype none
module tsm_device #(
    parameter int SYNC_TIMEOUT = `TSM_SYNC_TIMEOUT,
    parameter int WINDOW_REFS  = `TSM_WINDOW_REFS
)(
    // link to host
    tsm_link_if.device              link,
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // configuration pins
    input  wire logic               msg_source_i,
    input  wire logic               serial_sel_i,
    input  wire logic               aux_clock_i,
    input  wire logic [2:0]         resolution_i,
    // elapsed time
    output logic [31:0]             et_coarse_o,
    output logic [21:0]             et_fine_o,
    output logic                    sync_o,
    // message contents
    output logic [3:0]              time_chain_flags_o,
    output logic [7:0]              mission_flags_o,
    output logic [31:0]             pulse_field_o,
    output logic                    pulse_load_o,
    output logic [63:0]             waveform_field_o,
    output logic                    waveform_load_o,
    // errors and mode
    output logic                    msg_error_o,
    output logic                    sync_error_o,
    output logic                    window_viol_o,
    output tsm_pkg::tsm_mode_type   mode_o
);
    // ******************************************************
    // input synchronisers
    // ******************************************************
    logic [31:0] meta;
    logic [31:0] sync;
    logic [2:0]  prev;
    wire  [31:0] raw = {link.cs_n, link.wr_n, link.addr, link.data,
                        link.busclk, link.sin, link.oscillator_input,
                        msg_source_i, serial_sel_i, aux_clock_i,
                        resolution_i};
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            meta <= 32'hC0000000;
            sync <= 32'hC0000000;
            prev <= 3'h7;
        end
        else
        begin
            meta <= raw;
            sync <= meta;
            prev <= {sync[30], sync[8], sync[6]};
        end
    wire        s_cs_n  = sync[31];
    wire        s_wr_n  = sync[30];
    wire [4:0]  s_addr  = sync[29:25];
    wire [15:0] s_data  = sync[24:9];
    wire        s_bus   = sync[8];
    wire        s_sin   = sync[7];
    wire        s_osc   = sync[6];
    wire        s_src   = sync[5];
    wire        s_ser   = sync[4];
    wire        s_aux   = sync[3];
    wire [2:0]  s_res   = sync[2:0];
    wire        bus_rise = s_bus & ~prev[1];
    wire        osc_rise = s_osc & ~prev[0];
    // ******************************************************
    // mode decode
    // ******************************************************
    tsm_pkg::tsm_mode_type next_mode;
    assign next_mode = (s_src & s_ser) ? tsm_pkg::tsm_serial_mode :
        s_src ? (s_aux ? tsm_pkg::tsm_parallel_aux_clock_mode
                       : tsm_pkg::tsm_parallel_bus_clock_mode)
              : (s_aux ? tsm_pkg::tsm_standalone_aux_clock_mode
                       : tsm_pkg::tsm_standalone_bus_clock_mode);
    wire port_on  = (mode_o != tsm_pkg::tsm_serial_mode);
    wire alone    = (mode_o == tsm_pkg::tsm_standalone_bus_clock_mode) |
                    (mode_o == tsm_pkg::tsm_standalone_aux_clock_mode);
    wire aux_mode = (mode_o == tsm_pkg::tsm_parallel_aux_clock_mode) |
                    (mode_o == tsm_pkg::tsm_standalone_aux_clock_mode);
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            mode_o <= tsm_pkg::tsm_serial_mode;
        else
            mode_o <= next_mode;
    // ******************************************************
    // message port
    // ******************************************************
    logic [15:0] words [1:9];
    logic        in_msg;
    logic        msg_valid;
    logic        ready_n;
    wire wr_fall  = prev[2] & ~s_wr_n & ~s_cs_n & port_on;
    wire addr_ok  = (s_addr >= `TSM_ADDR_STATUS) &
                    (s_addr <= `TSM_ADDR_WAVE_LSW);
    wire pf       = words[1][`TSM_BIT_PULSE];
    wire wf       = words[1][`TSM_BIT_WAVE];
    wire last_wr  = wr_fall &
        (((s_addr == `TSM_ADDR_COARSE_LSW) & ~pf & ~wf) |
         ((s_addr == `TSM_ADDR_PULSE_LSW) & ~wf) |
         (s_addr == `TSM_ADDR_WAVE_LSW));
    wire first_wr = wr_fall & (s_addr == `TSM_ADDR_STATUS);
    assign link.ready_n = ready_n;
    genvar gi;
    generate
        for (gi = 1; gi <= 9; gi++)
        begin : g_word
            always_ff @(posedge clk_i or posedge rst_i)
                if (rst_i)
                    words[gi] <= 16'h0000;
                else if (wr_fall & (s_addr == 5'(gi)))
                    words[gi] <= s_data;
        end
    endgenerate
    // ******************************************************
    // phase references, window and timeout
    // ******************************************************
    logic [23:0] ref_cnt;
    logic [9:0]  ref_div;
    logic        sin_used;
    logic        window;
    wire slow_ref = (mode_o == tsm_pkg::tsm_parallel_aux_clock_mode) &
                    s_res[2];
    wire phase_ref = bus_rise &
                     (~slow_ref | (ref_div == 10'(`TSM_AUX_REF_DIV - 1)));
    wire marker  = bus_rise & s_sin & ~sin_used & port_on;
    wire use_msg = msg_valid & (~window_viol_o |
                   words[1][`TSM_BIT_INIT]);
    wire timeout = (ref_cnt == 24'(SYNC_TIMEOUT));
    assign link.window = window;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            ref_cnt  <= 24'h000000;
            ref_div  <= 10'h000;
            sin_used <= 1'b0;
            window   <= 1'b0;
        end
        else
        begin
            if (bus_rise)
                ref_div <= slow_ref ? ref_div + 10'h001 : 10'h000;
            if (marker)
                ref_cnt <= 24'h000000;
            else if (phase_ref & ~timeout)
                ref_cnt <= ref_cnt + 24'h000001;
            sin_used <= s_sin & (sin_used | bus_rise);
            window   <= port_on & (ref_cnt < 24'(WINDOW_REFS));
        end
    // ******************************************************
    // message tracking and errors
    // ******************************************************
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            in_msg        <= 1'b0;
            msg_valid     <= 1'b0;
            ready_n       <= 1'b1;
            window_viol_o <= 1'b0;
            msg_error_o   <= 1'b0;
            sync_error_o  <= 1'b0;
        end
        else
        begin
            // acknowledge held until the strobe returns high
            if (wr_fall & addr_ok)
                ready_n <= 1'b0;
            else if (s_wr_n)
                ready_n <= 1'b1;
            if (first_wr)
                in_msg <= 1'b1;
            else if (last_wr)
                in_msg <= 1'b0;
            // a newer message supersedes the stored one
            if (first_wr)
                msg_valid <= 1'b0;
            else if (last_wr & in_msg)
                msg_valid <= ~words[1][`TSM_BIT_ZERO];
            else if (marker)
                msg_valid <= 1'b0;
            if (first_wr)
                window_viol_o <= ~window;
            else if (in_msg & ~window)
                window_viol_o <= 1'b1;
            msg_error_o <= marker & ~use_msg & ~alone;
            if (marker & use_msg)
                sync_error_o <= 1'b0;
            else if (timeout & phase_ref & ~alone)
                sync_error_o <= 1'b1;
        end
    // ******************************************************
    // elapsed time counter
    // ******************************************************
    logic [1:0] dpll_div;
    wire dpll_tick = osc_rise & (dpll_div == 2'h3);
    wire et_tick   = aux_mode ? dpll_tick : bus_rise;
    wire [21:0] step = aux_mode ? 22'h000001 :
                       (22'h000001 << (2'h3 - s_res[1:0]));
    wire [22:0] fine_sum = {1'b0, et_fine_o} + {1'b0, step};
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            dpll_div    <= 2'h0;
            et_coarse_o <= 32'h00000000;
            et_fine_o   <= 22'h000000;
        end
        else
        begin
            if (osc_rise)
                dpll_div <= dpll_div + 2'h1;
            if (marker & use_msg)
            begin
                et_coarse_o <= {words[2], words[3]};
                et_fine_o   <= 22'h000000;
            end
            else if (et_tick & (port_on | alone))
            begin
                et_fine_o   <= fine_sum[21:0];
                et_coarse_o <= et_coarse_o + {31'h0, fine_sum[22]};
            end
        end
    // ******************************************************
    // field hand-off at synchronisation
    // ******************************************************
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            sync_o             <= 1'b0;
            pulse_load_o       <= 1'b0;
            waveform_load_o    <= 1'b0;
            time_chain_flags_o <= 4'h0;
            mission_flags_o    <= 8'h00;
            pulse_field_o      <= 32'h00000000;
            waveform_field_o   <= 64'h0;
        end
        else
        begin
            sync_o          <= marker & use_msg;
            pulse_load_o    <= marker & use_msg & pf;
            waveform_load_o <= marker & use_msg & wf;
            if (marker & use_msg)
            begin
                time_chain_flags_o <= words[1][11:8];
                mission_flags_o    <= words[1][7:0];
            end
            if (marker & use_msg & pf)
                pulse_field_o <= {words[4], words[5]};
            if (marker & use_msg & wf)
                waveform_field_o <= {words[6], words[7],
                                     words[8], words[9]};
        end
endmodule
`default_nettype wire

// file: hdl/tsm_host.sv
`include "tsm_cfg.svh"
`default_nettype none
module tsm_host #(
    parameter int BUS_HALF = `TSM_BUSCLK_NS / (2 * `TSM_CLK_NS),
    parameter int OSC_HALF = `TSM_OSC_NS / (2 * `TSM_CLK_NS)
)(
    // link to device
    tsm_link_if.host         link,
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // interrupt
    output logic             irq_o
);
    // ******************************************************
    // register file
    // ******************************************************
    logic [15:0] words [1:9];
    logic [1:0]  events;
    logic [1:0]  mask;
    logic [1:0]  rdy_meta;
    logic [1:0]  rdy_sync;
    tsm_pkg::tsm_host_state_type state;
    logic [4:0]  cur;
    logic [1:0]  done_ev;
    wire acc     = psel_i & penable_i;
    wire wr      = acc & pwrite_i;
    wire word_hit = (paddr_i >= `TSM_REG_WORD1) &
                    (paddr_i <= `TSM_REG_WORD9) & (paddr_i[1:0] == 2'h0);
    wire [3:0] widx = 4'(((paddr_i - `TSM_REG_WORD1) >> 2) + 8'h01);
    wire busy    = (state != tsm_pkg::tsm_h_idle);
    wire go_msg  = wr & (paddr_i == `TSM_REG_CTRL) & ~busy &
                   pwdata_i[`TSM_CTRL_SEND_MSG];
    wire go_mark = wr & (paddr_i == `TSM_REG_CTRL) & ~busy &
                   pwdata_i[`TSM_CTRL_SEND_MARK] &
                   ~pwdata_i[`TSM_CTRL_SEND_MSG];
    wire [31:0] rd_mux =
        (paddr_i == `TSM_REG_EVENT) ? {30'h0, events} :
        (paddr_i == `TSM_REG_MASK)  ? {30'h0, mask} :
        (paddr_i == `TSM_REG_BUSY)  ? {31'h0, busy} :
        word_hit ? {16'h0000, words[widx]} : 32'h00000000;
    wire [1:0] ev_clr = (wr & (paddr_i == `TSM_REG_EVENT)) ?
                        pwdata_i[1:0] : 2'h0;
    genvar gi;
    generate
        for (gi = 1; gi <= 9; gi++)
        begin : g_word
            always_ff @(posedge clk_i or posedge rst_i)
                if (rst_i)
                    words[gi] <= 16'h0000;
                else if (wr & word_hit & (widx == 4'(gi)) & ~busy)
                    words[gi] <= pwdata_i[15:0];
        end
    endgenerate
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            events    <= 2'h0;
            mask      <= 2'h0;
            irq_o     <= 1'b0;
        end
        else
        begin
            pready_o <= 1'b1;
            if (psel_i & ~penable_i)
                prdata_o <= rd_mux;
            if (wr & (paddr_i == `TSM_REG_MASK))
                mask <= pwdata_i[1:0];
            // a new event beats a clear in the same cycle
            events <= (events & ~ev_clr) | done_ev;
            irq_o  <= |(events & mask);
        end
    // ******************************************************
    // link clock generation
    // ******************************************************
    logic [7:0] bus_cnt;
    logic [7:0] osc_cnt;
    logic       busclk;
    logic       osc;
    wire bus_flip = (bus_cnt == 8'(BUS_HALF - 1));
    wire bus_rise = bus_flip & ~busclk;
    assign link.busclk           = busclk;
    assign link.oscillator_input = osc;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            bus_cnt <= 8'h00;
            osc_cnt <= 8'h00;
            busclk  <= 1'b0;
            osc     <= 1'b0;
        end
        else
        begin
            bus_cnt <= bus_flip ? 8'h00 : bus_cnt + 8'h01;
            busclk  <= busclk ^ bus_flip;
            osc_cnt <= (osc_cnt == 8'(OSC_HALF - 1)) ? 8'h00
                                                      : osc_cnt + 8'h01;
            osc     <= osc ^ (osc_cnt == 8'(OSC_HALF - 1));
        end
    // ******************************************************
    // message writer and marker
    // ******************************************************
    logic [4:0] next_cur;
    logic       last;
    wire pf = words[1][`TSM_BIT_PULSE];
    wire wf = words[1][`TSM_BIT_WAVE];
    always_comb
    begin
        last     = 1'b0;
        next_cur = cur + 5'h01;
        if (cur == `TSM_ADDR_COARSE_LSW)
        begin
            last     = ~pf & ~wf;
            next_cur = pf ? cur + 5'h01 : `TSM_ADDR_WAVE_MSW;
        end
        else if (cur == `TSM_ADDR_PULSE_LSW)
            last = ~wf;
        else if (cur == `TSM_ADDR_WAVE_LSW)
            last = 1'b1;
    end
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            rdy_meta <= 2'h3;
            rdy_sync <= 2'h3;
        end
        else
        begin
            rdy_meta <= {rdy_meta[0], link.ready_n};
            rdy_sync <= {rdy_sync[0], rdy_meta[1]};
        end
    wire dev_rdy_n = rdy_sync[1];
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            state     <= tsm_pkg::tsm_h_idle;
            cur       <= 5'h00;
            done_ev   <= 2'h0;
            link.cs_n <= 1'b1;
            link.wr_n <= 1'b1;
            link.addr <= 5'h00;
            link.data <= 16'h0000;
            link.sin  <= 1'b0;
        end
        else
        begin
            done_ev <= 2'h0;
            case (state)
                tsm_pkg::tsm_h_idle:
                    if (go_msg)
                    begin
                        cur   <= `TSM_ADDR_STATUS;
                        state <= tsm_pkg::tsm_h_setup;
                    end
                    else if (go_mark)
                        state <= tsm_pkg::tsm_h_marker;
                tsm_pkg::tsm_h_setup:
                begin
                    link.cs_n <= 1'b0;
                    link.addr <= cur;
                    link.data <= words[cur[3:0]];
                    state     <= tsm_pkg::tsm_h_strobe;
                end
                tsm_pkg::tsm_h_strobe:
                begin
                    link.wr_n <= 1'b0;
                    if (~dev_rdy_n)
                    begin
                        link.wr_n <= 1'b1;
                        state     <= tsm_pkg::tsm_h_release;
                    end
                end
                tsm_pkg::tsm_h_release:
                    if (dev_rdy_n)
                    begin
                        link.cs_n <= 1'b1;
                        cur       <= next_cur;
                        done_ev   <= {1'b0, last};
                        state     <= last ? tsm_pkg::tsm_h_idle
                                          : tsm_pkg::tsm_h_setup;
                    end
                tsm_pkg::tsm_h_marker:
                begin
                    link.sin <= 1'b1;
                    if (link.sin & bus_rise)
                        state <= tsm_pkg::tsm_h_mark_lo;
                end
                tsm_pkg::tsm_h_mark_lo:
                    if (bus_rise)
                    begin
                        link.sin <= 1'b0;
                        done_ev  <= 2'h2;
                        state    <= tsm_pkg::tsm_h_idle;
                    end
                default:
                    state <= tsm_pkg::tsm_h_idle;
            endcase
        end
endmodule
`default_nettype wire

// file: hdl/tsm_link_if.sv
`default_nettype none
interface tsm_link_if;
    logic        cs_n;
    logic        wr_n;
    logic [4:0]  addr;
    logic [15:0] data;
    logic        ready_n;
    logic        window;
    logic        busclk;
    logic        sin;
    logic        oscillator_input;
    modport host
    (
        output cs_n, wr_n, addr, data, busclk, sin, oscillator_input,
        input  ready_n, window
    );
    modport device
    (
        input  cs_n, wr_n, addr, data, busclk, sin, oscillator_input,
        output ready_n, window
    );
endinterface
`default_nettype wire

// file: hdl/tsm_pkg.sv
`default_nettype none
package tsm_pkg;
    typedef enum logic [4:0]
    {
        tsm_serial_mode                  = 5'h01,
        tsm_parallel_bus_clock_mode      = 5'h02,
        tsm_parallel_aux_clock_mode      = 5'h04,
        tsm_standalone_bus_clock_mode    = 5'h08,
        tsm_standalone_aux_clock_mode    = 5'h10
    } tsm_mode_type;
    typedef enum logic [5:0]
    {
        tsm_h_idle    = 6'h01,
        tsm_h_setup   = 6'h02,
        tsm_h_strobe  = 6'h04,
        tsm_h_release = 6'h08,
        tsm_h_marker  = 6'h10,
        tsm_h_mark_lo = 6'h20
    } tsm_host_state_type;
endpackage
`default_nettype wire

// file: testbench/testbench.sv
`include "tsm_cfg.svh"
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
    logic        pwrite_i = 0, msg_source_i = 1, serial_sel_i = 0;
    logic        aux_clock_i = 0, pready_o, pslverr_o, irq_o, sync_o;
    logic        pulse_load_o, waveform_load_o, msg_error_o;
    logic        sync_error_o, window_viol_o;
    logic [2:0]  resolution_i = 3'h0;
    logic [7:0]  paddr_i = 8'h00, mission_flags_o;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, et_coarse_o;
    logic [31:0] pulse_field_o;
    logic [21:0] et_fine_o;
    logic [3:0]  time_chain_flags_o;
    logic [63:0] waveform_field_o;
    logic [15:0] seed = 16'h0052, st;
    logic [15:0] wq[$];
    logic [2:0]  pins[5] = '{3'h4, 3'h5, 3'h2, 3'h1, 3'h6};
    int          fails = 0, cmp_count = 0, pl_n = 0, wl_n = 0, n, me_n = 0;
    tsm_pkg::tsm_mode_type mode_o;
    tsm_pkg::tsm_mode_type modes[5] = '{
        tsm_pkg::tsm_parallel_bus_clock_mode,
        tsm_pkg::tsm_parallel_aux_clock_mode,
        tsm_pkg::tsm_standalone_bus_clock_mode,
        tsm_pkg::tsm_standalone_aux_clock_mode, tsm_pkg::tsm_serial_mode};
    tsm_link_if lnk ();
    tsm_host i_tsm_host (.link(lnk), .clk_i, .rst_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .irq_o);
    // short counts keep the timeout within reach of the run
    tsm_device #(.SYNC_TIMEOUT(200), .WINDOW_REFS(50)) i_tsm_device (
        .link(lnk), .clk_i, .rst_i, .msg_source_i, .serial_sel_i,
        .aux_clock_i, .resolution_i, .et_coarse_o, .et_fine_o, .sync_o,
        .time_chain_flags_o, .mission_flags_o, .pulse_field_o,
        .pulse_load_o, .waveform_field_o, .waveform_load_o, .msg_error_o,
        .sync_error_o, .window_viol_o, .mode_o);
    tsm_monitor i_tsm_monitor (.clk_i, .rst_i, .cs_n(lnk.cs_n),
        .wr_n(lnk.wr_n), .addr(lnk.addr), .data(lnk.data),
        .ready_n(lnk.ready_n), .window(lnk.window), .busclk(lnk.busclk),
        .sin(lnk.sin), .oscillator_input(lnk.oscillator_input));
    always #4 clk_i = ~clk_i;
    // load and message error pulses counted off the active edge
    always @(negedge clk_i) pl_n += int'(pulse_load_o === 1'b1);
    always @(negedge clk_i) wl_n += int'(waveform_load_o === 1'b1);
    always @(negedge clk_i) me_n += int'(msg_error_o === 1'b1);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic limit(input int k, input int m);
        if (k >= m)
        begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++k < 40);
        limit(k, 40);
        rd = prdata_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic send(input int m);
        logic [3:0] step;
        seed = lfsr(seed);
        // init flag set: a message that misses the window is still used
        st = {1'b0, seed[14:13], 1'b1, seed[11:0]};
        wq = {st};
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            wq.push_back(seed);
        end
        apb(1, `TSM_REG_MASK, 32'h1);
        foreach (wq[i]) apb(1, 8'h10 + 8'(4 * i), {16'h0, wq[i]});
        apb(1, `TSM_REG_CTRL, 32'h1);
        n = 0;
        do apb(0, `TSM_REG_EVENT, 0); while (rd[0] !== 1'b1 && ++n < 300);
        limit(n, 300);
        `CHK(irq_o, 1'b1)
        `CHK(window_viol_o, 1'b0)
        apb(1, `TSM_REG_EVENT, 32'h1);
        apb(0, 8'hFC, 0);
        `CHK(rd, 32'h0)
        `CHK(pslverr_o, 1'b0)
        `CHK(irq_o, 1'b0)
        pl_n = 0;
        me_n = 0;
        wl_n = 0;
        apb(1, `TSM_REG_CTRL, 32'h2);
        n = 0;
        do @(negedge clk_i); while (sync_o !== 1'b1 && ++n < 3000);
        limit(n, 3000);
        `CHK(et_coarse_o, {wq[1], wq[2]})
        `CHK(et_fine_o[21:8], 14'h0)
        `CHK(time_chain_flags_o, st[11:8])
        `CHK(mission_flags_o, st[7:0])
        @(negedge clk_i);
        `CHK(pl_n, int'(st[14]))
        `CHK(wl_n, int'(st[13]))
        if (st[14]) `CHK(pulse_field_o, {wq[3], wq[4]})
        if (st[13])
            `CHK(waveform_field_o, {wq[5], wq[6], wq[7], wq[8]})
        repeat (4000) @(negedge clk_i);
        step = 4'h1 << (2'h3 - resolution_i[1:0]);
        // slow references keep mode 1 short of timeout, window open
        `CHK(sync_error_o, 1'(m == 0))
        `CHK(lnk.window, 1'(m == 1))
        `CHK(et_fine_o == 22'h0, 1'b0)
        if (!aux_clock_i) `CHK(et_fine_o[3:0] & (step - 4'h1), 4'h0)
        // a marker with no fresh message is a message error outside the standalone modes
        apb(1, `TSM_REG_CTRL, 32'h2);
        repeat (60) @(negedge clk_i);
        `CHK(me_n, int'(m < 2))
    endtask
    initial
    begin
        for (int m = 0; m < 5; m++)
        begin
            seed = lfsr(seed);
            {msg_source_i, serial_sel_i, aux_clock_i} <= pins[m];
            resolution_i <= {m == 1 || seed[2], seed[1:0]};
            rst_i <= 1'b1;
            repeat (8) @(posedge clk_i);
            rst_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            `CHK(mode_o, modes[m])
            `CHK(lnk.window, 1'(m < 4))
            if (m < 4) send(m);
            $display("mode case %0d done", m);
            @(posedge clk_i);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: testbench/tsm_monitor.sv
`default_nettype none
module tsm_monitor (
    // clock, reset and the link signals, named as on the interface
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cs_n,
    input wire logic        wr_n,
    input wire logic [4:0]  addr,
    input wire logic [15:0] data,
    input wire logic        ready_n,
    input wire logic        window,
    input wire logic        busclk,
    input wire logic        sin,
    input wire logic        oscillator_input
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       wr_q;
    logic [4:0] last_a;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) wr_q <= 1'b1;
        else wr_q <= wr_n;
    // last word address, to judge the next one
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) last_a <= 5'h00;
        else if (wr_q && !wr_n) last_a <= addr;
    ack_cause_a: assert property (
        $fell(ready_n) |-> !$past(wr_n) && !$past(wr_n, 3))
        else $error("ack without a held strobe");
    ack_bound_a: assert property (
        $fell(wr_n) && !cs_n && addr inside {[5'h01:5'h09]}
        |-> ##[2:8] !ready_n) else $error("word not acknowledged");
    ack_release_a: assert property (
        $rose(wr_n) |-> ##[1:8] ready_n) else $error("ack held too long");
    ack_select_a: assert property (
        !ready_n |-> !cs_n) else $error("ack while not selected");
    strobe_hold_a: assert property (
        !wr_n && !$fell(wr_n) |-> $stable(addr) && $stable(data))
        else $error("word changed under strobe");
    word_order_a: assert property (
        $fell(wr_n) && addr != 5'h01 |-> addr == last_a + 5'h01
        || (addr == 5'h06 && last_a == 5'h03)) else $error("word order");
    marker_hold_a: assert property (
        $rose(sin) |-> sin[*8]) else $error("marker request too short");
    busclk_half_a: assert property (
        $rose(busclk) |-> busclk[*7] ##1 !busclk)
        else $error("phase clock high time");
    osc_half_a: assert property (
        $rose(oscillator_input) |-> oscillator_input[*3]
        ##1 !oscillator_input) else $error("oscillator high time");
    cover property ($fell(ready_n));
    cover property ($rose(sin));
    cover property ($rose(window));
endmodule
`default_nettype wire
